//--- logic/artc_top.sv
// auto-retry transmit sequencer with apb register access and radio event gating
// assumes the radio core gives one-cycle pulses on its inputs, synchronous to sys_clk
`timescale 1ns/10ps
module artc_top #(
  parameter int unsigned ACK_SYMBOLS = artc_pkg::ACK_WAIT_SYMBOLS,
  parameter int unsigned SYM_CYC     = artc_pkg::SYM_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // channel access
  output logic             cca_req,
  input  wire logic        cca_done,
  input  wire logic        cca_idle,
  // frame transmit
  output logic             tx_req,
  input  wire logic        tx_done,
  input  wire logic [7:0]  frame_first_octet,
  // receive path
  output logic             rx_listen,
  output logic             rx_buf_wr_en,
  input  wire logic        rx_phr_valid,
  input  wire logic        rx_addr_match,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_is_ack,
  input  wire logic        rx_fcs_ok,
  input  wire logic        rx_pending,
  input  wire logic        ack_tx_done,
  // events towards the processor
  output logic             transmit_end_irq,
  output logic             receive_start_irq,
  output logic             address_match_irq,
  output logic             receive_end_irq,
  output logic             synth_lock_irq
);
  import artc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    artc_mode_t  mode;
    artc_eng_t   eng;
    logic [2:0]  result;
    logic [2:0]  acc_lim;
    logic [3:0]  frm_lim;
    logic [4:0]  mask;
    logic [2:0]  acc_cnt;
    logic [3:0]  frm_cnt;
    logic        once;
    logic        ack_req;
    logic        waiting;
    logic [11:0] sym_div;
    logic [7:0]  sym_cnt;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        cca_req;
    logic        tx_req;
    logic        rx_listen;
    logic        rx_buf_wr_en;
    logic [4:0]  irq;
  } artc_state_t;

  artc_state_t s_reg;
  artc_state_t s_next;
  logic [1:0]  rst_sync_reg;
  logic        rst_n_int;

  // ==========================================================
  // reset release
  // assertion is immediate, release waits two edges so no flop leaves reset on its own
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n_int = rst_sync_reg[1];

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  localparam logic [11:0] SYM_LAST = 12'(SYM_CYC - 1);
  localparam logic [7:0]  ACK_LAST = 8'(ACK_SYMBOLS - 1);

  logic       acc;
  logic       wr;
  logic [2:0] cmd;
  logic       start;
  logic [4:0] ev;

  // ==========================================================
  // next state
  always_comb
  begin
    s_next         = s_reg;
    s_next.cca_req = 1'b0;
    s_next.tx_req  = 1'b0;
    ev             = 5'h00;
    start          = 1'b0;
    // apb: one wait state, so pready and prdata are plain flops
    acc = psel && penable && !s_reg.pready;
    wr  = acc && pwrite;
    cmd = pwdata[CMD_LSB +: 3];
    s_next.pready  = acc;
    s_next.pslverr = 1'b0;
    s_next.prdata  = 32'h0;
    if (acc)
    begin
      if (hit(paddr, STATE_CTRL_OFS))
        s_next.prdata = {24'h0, s_reg.result, 5'h00};
      else if (hit(paddr, RADIO_STAT_OFS))
        s_next.prdata = {29'h0, s_reg.mode};
      else if (hit(paddr, RETRY_CTRL_OFS))
        s_next.prdata = {24'h0, s_reg.frm_lim, s_reg.acc_lim, 1'b0};
      else if (hit(paddr, TRIGGER_OFS))
        s_next.prdata = 32'h0;
      else if (hit(paddr, EVENT_MASK_OFS))
        s_next.prdata = {27'h0, s_reg.mask};
      else
        s_next.pslverr = 1'b1;
    end

    // register writes and mode commands
    if (wr && hit(paddr, RETRY_CTRL_OFS))
    begin
      s_next.acc_lim = pwdata[ACC_LIM_LSB +: 3];
      s_next.frm_lim = pwdata[FRM_LIM_LSB +: 4];
    end
    if (wr && hit(paddr, EVENT_MASK_OFS))
      s_next.mask = pwdata[4:0];
    if (wr && hit(paddr, STATE_CTRL_OFS) && s_reg.eng == ARTC_IDLE)
    begin
      case (cmd)
        CMD_RADIO_OFF:
          s_next.mode = ARTC_ST_OFF;
        CMD_SYNTH_ON:
          s_next.mode = ARTC_ST_SYNTH;
        CMD_ARET_MODE:
        begin
          if (s_reg.mode != ARTC_ST_ARET_IDLE)
            s_next.result = RES_INVALID;
          if (s_reg.mode == ARTC_ST_OFF)
            ev[4] = 1'b1;
          s_next.mode = ARTC_ST_ARET_IDLE;
        end
        CMD_AACK_MODE:
        begin
          if (s_reg.mode == ARTC_ST_OFF)
            ev[4] = 1'b1;
          s_next.mode = ARTC_ST_AACK;
        end
        CMD_TX_START:
          start = (s_reg.mode == ARTC_ST_ARET_IDLE);
        default:
          start = 1'b0;
      endcase
    end
    if (wr && hit(paddr, TRIGGER_OFS) && pwdata[TRIG_BIT] &&
        s_reg.mode == ARTC_ST_ARET_IDLE && s_reg.eng == ARTC_IDLE)
      start = 1'b1;

    // symbol divider runs only while waiting for a reply
    // it is cleared on entry to the wait, so every timeout counts from zero
    if (s_reg.waiting)
    begin
      if (s_reg.sym_div == SYM_LAST)
      begin
        s_next.sym_div = 12'h000;
        s_next.sym_cnt = s_reg.sym_cnt + 8'h01;
      end
      else
        s_next.sym_div = s_reg.sym_div + 12'h001;
    end

    // transaction engine
    case (s_reg.eng)
      ARTC_IDLE:
      begin
        if (start)
        begin
          s_next.acc_cnt = 3'h0;
          s_next.frm_cnt = 4'h0;
          s_next.mode    = ARTC_ST_ARET_BUSY;
          s_next.once    = (s_reg.acc_lim == ACC_NO_CCA);
          if (s_reg.acc_lim == ACC_NO_CCA)
          begin
            s_next.eng    = ARTC_TX;
            s_next.tx_req = 1'b1;
          end
          else
          begin
            s_next.eng     = ARTC_CCA;
            s_next.cca_req = 1'b1;
          end
        end
      end
      ARTC_CCA:
      begin
        // the first check is not a retry: a limit of n gives n + 1 checks
        if (cca_done)
        begin
          if (cca_idle)
          begin
            s_next.eng    = ARTC_TX;
            s_next.tx_req = 1'b1;
          end
          else if (s_reg.acc_cnt == s_reg.acc_lim)
          begin
            s_next.result = RES_CHAN_BUSY;
            s_next.eng    = ARTC_END;
          end
          else
          begin
            s_next.acc_cnt = s_reg.acc_cnt + 3'h1;
            s_next.cca_req = 1'b1;
          end
        end
      end
      ARTC_TX:
      begin
        // the octet is taken once, just after the request, and held for the whole frame
        if (s_reg.tx_req)
          s_next.ack_req = frame_first_octet[ACK_REQ_BIT];
        if (tx_done)
        begin
          if (s_reg.ack_req)
          begin
            s_next.eng       = ARTC_ACK;
            s_next.rx_listen = 1'b1;
            s_next.waiting   = 1'b1;
            s_next.sym_div   = 12'h000;
            s_next.sym_cnt   = 8'h00;
          end
          else
          begin
            s_next.result = RES_OK;
            s_next.eng    = ARTC_END;
          end
        end
      end
      ARTC_ACK:
      begin
        // anything but a clean acknowledgement is dropped here
        if (rx_frame_done && rx_is_ack && rx_fcs_ok)
        begin
          s_next.result    = rx_pending ? RES_OK_PENDING : RES_OK;
          s_next.eng       = ARTC_END;
          s_next.rx_listen = 1'b0;
          s_next.waiting   = 1'b0;
        end
        // a reply in the last cycle of the wait still counts
        else if (s_reg.sym_cnt == ACK_LAST && s_reg.sym_div == SYM_LAST)
        begin
          s_next.rx_listen = 1'b0;
          s_next.waiting   = 1'b0;
          if (s_reg.once || s_reg.frm_cnt == s_reg.frm_lim)
          begin
            s_next.result = RES_NO_ACK;
            s_next.eng    = ARTC_END;
          end
          else
          begin
            s_next.frm_cnt = s_reg.frm_cnt + 4'h1;
            s_next.acc_cnt = 3'h0;
            s_next.eng     = ARTC_CCA;
            s_next.cca_req = 1'b1;
          end
        end
      end
      ARTC_END:
      begin
        ev[0]       = 1'b1;
        s_next.mode = ARTC_ST_ARET_IDLE;
        s_next.eng  = ARTC_IDLE;
      end
      default:
        s_next.eng = ARTC_IDLE;
    endcase

    // receive events only in auto-reply receive mode, never for acknowledgements
    if (s_reg.mode == ARTC_ST_AACK && !rx_is_ack)
    begin
      ev[1] = rx_phr_valid;
      ev[2] = rx_addr_match;
      ev[3] = rx_frame_done && rx_addr_match && rx_fcs_ok;
    end
    if (s_reg.mode == ARTC_ST_AACK && ack_tx_done)
      ev[0] = 1'b1;

    // frame buffer is written by reception only in receive mode
    s_next.rx_buf_wr_en = (s_next.mode == ARTC_ST_AACK);
    s_next.irq          = ev & s_reg.mask;
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      s_reg              <= '0;
      s_reg.mode         <= ARTC_ST_OFF;
      s_reg.eng          <= ARTC_IDLE;
      s_reg.result       <= RES_INVALID;
      s_reg.acc_lim      <= ACC_LIM_RST;
      s_reg.frm_lim      <= FRM_LIM_RST;
      s_reg.mask         <= EVENT_MASK_RST;
    end
    else
      s_reg <= s_next;
  end

  // ==========================================================
  // outputs
  // every output is a plain flop copy, so no glitch reaches the radio or the processor
  assign pready            = s_reg.pready;
  assign prdata            = s_reg.prdata;
  assign pslverr           = s_reg.pslverr;
  assign cca_req           = s_reg.cca_req;
  assign tx_req            = s_reg.tx_req;
  assign rx_listen         = s_reg.rx_listen;
  assign rx_buf_wr_en      = s_reg.rx_buf_wr_en;
  assign transmit_end_irq  = s_reg.irq[0];
  assign receive_start_irq = s_reg.irq[1];
  assign address_match_irq = s_reg.irq[2];
  assign receive_end_irq   = s_reg.irq[3];
  assign synth_lock_irq    = s_reg.irq[4];

endmodule

//--- pkg/artc_pkg.sv
// constants, codes and types of the auto-retry transmit control block
// assumes one 250 MHz clock and an apb master reaching the registers
//
// Overview of operation
// - transaction starts on trigger bit write or transmit-start command write
// - busy channel retried up to access limit, then abort with result 3
// - bit 5 of first frame octet says whether an acknowledgement is awaited
// - with acknowledgement requested, listen after sending and parse pending subfield
// - acknowledgement reception never writes frame buffer; other frames discarded
// - no acknowledgement within 54 symbols repeats transaction until frame limit exceeded
// - result codes: 0 ok, 1 ok pending, 3 channel busy, 5 no acknowledgement
// - entering auto-retry transmit mode sets result to 7 until completion
// - no acknowledgement requested: transmit end right after sending, result 0
// - access limit 7 sends at once without access check, exactly once
// - status reads busy during the transaction, idle auto-retry state afterwards
// - good acknowledgement gives result 0, or 1 when its pending bit is set
// - auto-reply receive mode signals receive start on valid length header
// - receive end only for address-matched frames with valid checksum
// - auto-reply receive mode signals own acknowledgement sent with transmit end
// - auto-retry transmit end fires only after whole transaction with retries
// - acknowledgement frames never raise receive start, address match or receive end
// - entering either auto mode from radio off raises synthesizer lock event
// - each start with access limit below 7 does channel access first, frame sent only on idle channel
package artc_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned SYMBOL_PS        = 16000000;
  localparam int unsigned SYM_CYCLES       = SYMBOL_PS / CLK_PERIOD_PS;
  localparam int unsigned ACK_WAIT_SYMBOLS = 54;
  localparam int unsigned ACK_WAIT_US      = 864;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] STATE_CTRL_OFS  = 12'h000;
  localparam logic [11:0] RADIO_STAT_OFS  = 12'h004;
  localparam logic [11:0] RETRY_CTRL_OFS  = 12'h008;
  localparam logic [11:0] TRIGGER_OFS     = 12'h00c;
  localparam logic [11:0] EVENT_MASK_OFS  = 12'h010;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned CMD_LSB         = 0;
  localparam int unsigned RESULT_LSB      = 5;
  localparam int unsigned ACC_LIM_LSB     = 1;
  localparam int unsigned FRM_LIM_LSB     = 4;
  localparam int unsigned TRIG_BIT        = 0;
  localparam int unsigned ACK_REQ_BIT     = 5;
  localparam logic [2:0]  ACC_LIM_RST     = 3'h4;
  localparam logic [3:0]  FRM_LIM_RST     = 4'h3;
  localparam logic [4:0]  EVENT_MASK_RST  = 5'h00;
  localparam logic [2:0]  ACC_NO_CCA      = 3'h7;

  // ==========================================================
  // result codes
  localparam logic [2:0] RES_OK           = 3'h0;
  localparam logic [2:0] RES_OK_PENDING   = 3'h1;
  localparam logic [2:0] RES_CHAN_BUSY    = 3'h3;
  localparam logic [2:0] RES_NO_ACK       = 3'h5;
  localparam logic [2:0] RES_INVALID      = 3'h7;

  // ==========================================================
  // state control commands
  localparam logic [2:0] CMD_NOP          = 3'h0;
  localparam logic [2:0] CMD_RADIO_OFF    = 3'h1;
  localparam logic [2:0] CMD_SYNTH_ON     = 3'h2;
  localparam logic [2:0] CMD_TX_START     = 3'h3;
  localparam logic [2:0] CMD_ARET_MODE    = 3'h4;
  localparam logic [2:0] CMD_AACK_MODE    = 3'h5;

  // status codes reported by the radio status register
  typedef enum logic [2:0] {
    ARTC_ST_OFF       = 3'h0,
    ARTC_ST_SYNTH     = 3'h1,
    ARTC_ST_ARET_IDLE = 3'h2,
    ARTC_ST_ARET_BUSY = 3'h3,
    ARTC_ST_AACK      = 3'h4
  } artc_mode_t;

  // transaction engine, gray along idle-cca-tx-ack-end
  typedef enum logic [2:0] {
    ARTC_IDLE = 3'b000,
    ARTC_CCA  = 3'b001,
    ARTC_TX   = 3'b011,
    ARTC_ACK  = 3'b010,
    ARTC_END  = 3'b110
  } artc_eng_t;

endpackage

//--- tb/artc_properties.sv
// concurrent checks on the auto-retry transmit control top ports
// assumes bind into artc_top; mask and access limit are mirrored from apb writes
`timescale 1ns/10ps
module artc_properties
  import artc_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // radio side
  input wire logic        cca_req,
  input wire logic        cca_done,
  input wire logic        cca_idle,
  input wire logic        tx_req,
  input wire logic        tx_done,
  input wire logic [7:0]  frame_first_octet,
  input wire logic        rx_listen,
  input wire logic        rx_buf_wr_en,
  input wire logic        rx_phr_valid,
  input wire logic        rx_addr_match,
  input wire logic        rx_frame_done,
  input wire logic        rx_is_ack,
  input wire logic        rx_fcs_ok,
  input wire logic        ack_tx_done,
  // events
  input wire logic        transmit_end_irq,
  input wire logic        receive_start_irq,
  input wire logic        address_match_irq,
  input wire logic        receive_end_irq,
  input wire logic        synth_lock_irq
);
  typedef struct packed {
    logic [4:0] mask;
    logic [2:0] acc;
  } artc_chk_t;
  artc_chk_t cur_reg;
  artc_chk_t cur_next;
  logic      wr;
  logic [4:0] irqv;

  // ==========================================================
  // mirror
  // the mirror lags the design by one cycle, so the bench keeps events away from mask writes
  assign wr   = psel & penable & pready & pwrite;
  assign irqv = {synth_lock_irq, receive_end_irq, address_match_irq, receive_start_irq, transmit_end_irq};
  always_comb
  begin
    cur_next = cur_reg;
    if (wr && paddr == EVENT_MASK_OFS)
      cur_next.mask = pwdata[4:0];
    if (wr && paddr == RETRY_CTRL_OFS)
      cur_next.acc = pwdata[3:1];
  end
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      cur_reg <= {EVENT_MASK_RST, ACC_LIM_RST};
    else
      cur_reg <= cur_next;

  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_listen_after_tx: assert property (
    tx_done && frame_first_octet[ACK_REQ_BIT] |=> rx_listen) else $error("no listening after frame");
  a_end_no_ack: assert property (
    tx_done && !frame_first_octet[ACK_REQ_BIT] && cur_reg.mask[0] |=> !rx_listen ##1 transmit_end_irq)
    else $error("no end event after frame without ack request");
  a_ack_closes: assert property (
    rx_listen && rx_frame_done && rx_is_ack && rx_fcs_ok |=> !rx_listen ##1 (transmit_end_irq || !cur_reg.mask[0]))
    else $error("ack did not close the transaction");
  a_junk_kept: assert property (
    rx_listen && rx_frame_done && !rx_is_ack |=> rx_listen) else $error("foreign frame ended listening");
  a_buf_locked: assert property (
    rx_listen |-> !rx_buf_wr_en) else $error("buffer writable while awaiting ack");
  a_no_cca_lim7: assert property (
    cur_reg.acc == ACC_NO_CCA |-> !cca_req) else $error("channel check with limit seven");
  a_cca_before_tx: assert property (
    tx_req && cur_reg.acc != ACC_NO_CCA |-> $past(cca_done && cca_idle)) else $error("frame sent without idle check");
  a_ack_silent: assert property (
    (rx_phr_valid || rx_addr_match || rx_frame_done) && rx_is_ack
    |=> !(receive_start_irq || address_match_irq || receive_end_irq) [*2]) else $error("ack raised rx event");
  a_irq_gated: assert property (
    (irqv & ~cur_reg.mask) == 5'h00) else $error("masked event reached output");
  a_ack_tx_end: assert property (
    ack_tx_done && cur_reg.mask[0] |-> ##[1:2] transmit_end_irq) else $error("no end event after own ack");
  c_listen: cover property (rx_listen && rx_frame_done && rx_is_ack);
  c_tx_end: cover property (transmit_end_irq);
  c_lock: cover property (synth_lock_irq);
endmodule

bind artc_top artc_properties u_chk (.*);

//--- tb/artc_radio_model.sv
// radio core stand-in: channel check, frame send and acknowledgement reply
// assumes the block's requests are one-cycle pulses on sys_clk
`timescale 1ns/10ps
module artc_radio_model (
  // clock
  input  wire logic       sys_clk,
  // requests from the block
  input  wire logic       cca_req,
  input  wire logic       tx_req,
  input  wire logic       rx_listen,
  // scenario control: checks counted up to busy_n answer busy; ack reply 0 none 1 ok 2 pending 3 foreign first
  input  wire logic [31:0] busy_n,
  input  wire logic [1:0] ack_mode,
  // answers
  output logic            cca_done,
  output logic            cca_idle,
  output logic            tx_done,
  output logic            rx_phr_valid,
  output logic            rx_addr_match,
  output logic            rx_frame_done,
  output logic            rx_is_ack,
  output logic            rx_fcs_ok,
  output logic            rx_pending,
  // request counts
  output int              n_cca,
  output int              n_tx
);
  initial
  begin
    {cca_done, cca_idle, tx_done, rx_phr_valid, rx_addr_match} = '0;
    {rx_frame_done, rx_is_ack, rx_fcs_ok, rx_pending} = '0;
    n_cca = 0;
    n_tx = 0;
  end

  // levels are inverted after use, address match cleared, so no stale level keeps the last frame's value
  task automatic frame(input logic ack, input logic match, input logic fcs, input logic pend);
    rx_is_ack <= ack;
    rx_phr_valid <= 1'b1;
    @(posedge sys_clk);
    rx_phr_valid <= 1'b0;
    rx_addr_match <= match;
    rx_fcs_ok <= fcs;
    rx_pending <= pend;
    rx_frame_done <= 1'b1;
    @(posedge sys_clk);
    rx_frame_done <= 1'b0;
    rx_addr_match <= 1'b0;
    rx_fcs_ok <= ~fcs;
    rx_pending <= ~pend;
    rx_is_ack <= ~ack;
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
    if (cca_req)
    begin
      n_cca <= n_cca + 1;
      repeat (4) @(posedge sys_clk);
      cca_idle <= n_cca > busy_n;
      cca_done <= 1'b1;
      @(posedge sys_clk);
      cca_done <= 1'b0;
      cca_idle <= ~cca_idle;
    end

  always @(posedge sys_clk)
    if (tx_req)
    begin
      n_tx <= n_tx + 1;
      repeat (3 + n_tx % 2) @(posedge sys_clk);
      tx_done <= 1'b1;
      @(posedge sys_clk);
      tx_done <= 1'b0;
    end

  always @(posedge sys_clk)
    if ($rose(rx_listen) && ack_mode != 2'h0)
    begin
      repeat (3) @(posedge sys_clk);
      if (ack_mode == 2'h3)
        frame(1'b0, 1'b1, 1'b1, 1'b0);
      frame(1'b1, 1'b0, 1'b1, ack_mode == 2'h2);
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the auto-retry transmit control block
// assumes the radio model and the bound checker from tb/
`timescale 1ns/10ps
module tb_top;
  import artc_pkg::*;
  localparam int ACK_T = 20;
  typedef struct packed {
    logic [2:0] acc;
    logic [3:0] frm;
    logic [3:0] busy;
    logic [1:0] mode;
    logic [7:0] oct;
    logic [2:0] res;
    logic [3:0] ncca;
    logic [3:0] ntx;
  } artc_row_t;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        ack_tx_done = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  frame_first_octet = 8'h00;
  logic [31:0] busy_n = 32'h0;
  logic [1:0]  ack_mode = 2'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, cca_req, tx_req, rx_listen, rx_buf_wr_en, err;
  logic        cca_done, cca_idle, tx_done, rx_phr_valid, rx_addr_match;
  logic        rx_frame_done, rx_is_ack, rx_fcs_ok, rx_pending;
  logic        transmit_end_irq, receive_start_irq, address_match_irq, receive_end_irq, synth_lock_irq;
  int          n_cca, n_tx, n_fail = 0, checks_done = 0, n_lis = 0;
  int          cnt [5] = '{default: 0};
  int          snap [5];
  logic [5:0]  ftab [4] = '{6'b011111, 6'b010110, 6'b001100, 6'b111000};
  artc_row_t   rows [12] = '{
    '{3'h4, 4'h3, 4'h0, 2'h0, 8'h01, RES_OK, 4'h1, 4'h1}, '{3'h4, 4'h3, 4'h0, 2'h1, 8'h21, RES_OK, 4'h1, 4'h1},
    '{3'h4, 4'h3, 4'h0, 2'h2, 8'h21, RES_OK_PENDING, 4'h1, 4'h1}, '{3'h4, 4'h3, 4'h0, 2'h3, 8'h21, RES_OK, 4'h1, 4'h1},
    '{3'h4, 4'h3, 4'h2, 2'h0, 8'h01, RES_OK, 4'h3, 4'h1}, '{3'h4, 4'h3, 4'h4, 2'h0, 8'h01, RES_OK, 4'h5, 4'h1},
    '{3'h4, 4'h3, 4'h5, 2'h0, 8'h01, RES_CHAN_BUSY, 4'h5, 4'h0}, '{3'h0, 4'h3, 4'h1, 2'h1, 8'h21, RES_CHAN_BUSY, 4'h1, 4'h0},
    '{3'h4, 4'h3, 4'h0, 2'h0, 8'h21, RES_NO_ACK, 4'h4, 4'h4}, '{3'h4, 4'h0, 4'h0, 2'h0, 8'h21, RES_NO_ACK, 4'h1, 4'h1},
    '{3'h7, 4'h3, 4'h9, 2'h0, 8'h21, RES_NO_ACK, 4'h0, 4'h1}, '{3'h7, 4'h3, 4'h9, 2'h1, 8'h21, RES_OK, 4'h0, 4'h1}};
  wire [4:0]   irqv = {synth_lock_irq, receive_end_irq, address_match_irq, receive_start_irq, transmit_end_irq};

  artc_top #(.ACK_SYMBOLS(2), .SYM_CYC(10)) dut (.*);
  artc_radio_model u_rad (.*);

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    foreach (cnt[i]) cnt[i] += irqv[i];
    n_lis += rx_listen;
  end

  // ==========================================================
  // reporting
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic fail();
    n_fail++;
    $display("mismatch at %0t: wait ran out", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // ==========================================================
  // bus and transaction helpers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) fail();
    @(posedge sys_clk);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 200; k++)
    begin
      apb(1'b0, RADIO_STAT_OFS, 32'h0);
      if (rd[2:0] === ARTC_ST_ARET_IDLE) break;
    end
    if (k == 200) fail();
  endtask
  task automatic run(input artc_row_t r, input int nirq, input logic trig);
    int c0, t0, l0;
    apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_SYNTH_ON});
    apb(1'b1, RETRY_CTRL_OFS, {24'h0, r.frm, r.acc, 1'b0});
    apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_ARET_MODE});
    apb(1'b0, STATE_CTRL_OFS, 32'h0);
    chk(rd[7:5], RES_INVALID);
    // the model counts checks over the whole run, so the busy count is made absolute
    busy_n <= 32'(n_cca) + 32'(r.busy);
    ack_mode <= r.mode;
    frame_first_octet <= r.oct;
    c0 = n_cca;
    t0 = n_tx;
    l0 = n_lis;
    snap = cnt;
    if (trig)
      apb(1'b1, TRIGGER_OFS, 32'h1);
    else
      apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_TX_START});
    apb(1'b0, RADIO_STAT_OFS, 32'h0);
    chk(rd, {29'h0, ARTC_ST_ARET_BUSY});
    wait_idle();
    apb(1'b0, STATE_CTRL_OFS, 32'h0);
    chk(rd[7:5], r.res);
    chk(n_cca - c0, r.ncca);
    chk(n_tx - t0, r.ntx);
    chk(cnt[0] - snap[0], nirq);
    if (r.mode == 2'h0 && r.oct[5])
      chk(n_lis - l0 >= (ACK_T - 1) * r.ntx && n_lis - l0 <= (ACK_T + 1) * r.ntx, 1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, STATE_CTRL_OFS, 32'h0);
    chk(rd[7:5], RES_INVALID);
    apb(1'b0, RETRY_CTRL_OFS, 32'h0);
    chk(rd, {24'h0, FRM_LIM_RST, ACC_LIM_RST, 1'b0});
    apb(1'b0, RADIO_STAT_OFS, 32'h0);
    chk(rd, {29'h0, ARTC_ST_OFF});
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, EVENT_MASK_OFS, 32'h1f);
    apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_ARET_MODE});
    repeat (3) @(posedge sys_clk);
    chk(cnt[4], 1);
    apb(1'b0, STATE_CTRL_OFS, 32'h0);
    chk(rd[7:5], RES_INVALID);
    foreach (rows[i]) run(rows[i], 1, i[0]);
    apb(1'b1, EVENT_MASK_OFS, 32'h1e);
    run(rows[0], 0, 1'b0);
    apb(1'b1, EVENT_MASK_OFS, 32'h1f);
    apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_RADIO_OFF});
    apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_AACK_MODE});
    repeat (3) @(posedge sys_clk);
    chk(cnt[4], 2);
    chk(rx_buf_wr_en, 1'b1);
    foreach (ftab[i])
    begin
      snap = cnt;
      u_rad.frame(ftab[i][5], ftab[i][4], ftab[i][3], 1'b0);
      repeat (4) @(posedge sys_clk);
      chk(cnt[1] - snap[1], ftab[i][2]);
      chk(cnt[2] - snap[2], ftab[i][1]);
      chk(cnt[3] - snap[3], ftab[i][0]);
    end
    snap = cnt;
    ack_tx_done <= 1'b1;
    @(posedge sys_clk);
    ack_tx_done <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(cnt[0] - snap[0], 1);
    // reset in mid-transaction must drop listen, both requests, pready and every event, and restore the reset state
    apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_RADIO_OFF});
    apb(1'b1, STATE_CTRL_OFS, {29'h0, CMD_ARET_MODE});
    frame_first_octet <= 8'h21;
    apb(1'b1, TRIGGER_OFS, 32'h1);
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({rx_listen, tx_req, cca_req, pready, irqv}, 32'h0);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, RADIO_STAT_OFS, 32'h0);
    chk(rd, {29'h0, ARTC_ST_OFF});
    apb(1'b0, STATE_CTRL_OFS, 32'h0);
    chk(rd[7:5], RES_INVALID);
    final_report();
  end
endmodule
